// ==== include/ahm_consts.svh ====
// constants for the alarm minute/hour match register block
// assumes inclusion by bare name from logic/ files
//
// Contract
// R1: minute register bit 7 always reads zero
// R2: minute bits 6-4 hold BCD tens 0-5
// R3: minute bits 3-0 hold BCD ones 0-9
// R4: 24-hour mode bits 5-4 hold tens 0-2
// R5: hour bits 3-0 hold BCD ones 0-9
// R6: hour bit 6 read-only format; 12h uses PM
// R7: three-bit select 001 minutes, 010 hours match
// R8: match sets flag in hardware, software clears
// R9: values stored and compared as BCD
`ifndef AHM_CONSTS_SVH
`define AHM_CONSTS_SVH

// register pointer values on the serial bus
`define AHM_ALM0_MIN_ADDR  8'h0B
`define AHM_ALM0_HOUR_ADDR 8'h0C
`define AHM_ALM1_MIN_ADDR  8'h12
`define AHM_ALM1_HOUR_ADDR 8'h13
// implemented bits of each register
`define AHM_MIN_MASK       8'h7F
`define AHM_HOUR_MASK      8'h3F
`define AHM_FMT_BIT        6
`define AHM_RESET_BYTE     8'h00
// alarm_match_select codes handled here
`define AHM_SEL_MIN        3'h1
`define AHM_SEL_HOUR       3'h2
// serial slave address, value is arbitrary
`define AHM_DEV_ADDR       7'h5A
`define AHM_BYTE_BITS      4'h8
`define AHM_LAST_BIT       4'h7

`endif

// ==== include/ahm_pkg.sv ====
// types shared by the alarm match register block
// assumes nothing beyond a SystemVerilog compiler
package ahm_pkg;
   typedef logic [7:0] ahm_byte_t;
   typedef logic [1:0] ahm_idx_t;
   typedef enum {
      AHM_IDLE,
      AHM_ADDR,
      AHM_ADDR_ACK,
      AHM_PTR,
      AHM_PTR_ACK,
      AHM_WDATA,
      AHM_WDATA_ACK,
      AHM_RDATA,
      AHM_RACK
   } ahm_state_t;
endpackage

// ==== include/ahm_mem_if.sv ====
// carrier between the serial engine and the match value store
// assumes one clock shared by both ends
`timescale 1ns/1ps
interface ahm_mem_if;
   logic                       we;
   ahm_pkg::ahm_idx_t          waddr;
   ahm_pkg::ahm_byte_t         wdata;
   ahm_pkg::ahm_idx_t          raddr;
   ahm_pkg::ahm_byte_t         rdata;
   ahm_pkg::ahm_byte_t [3:0]   vals;
   modport ctrl (output we, output waddr, output wdata, output raddr,
                 input rdata, input vals);
   modport mem  (input we, input waddr, input wdata, input raddr,
                 output rdata, output vals);
endinterface

// ==== logic/ahm_match_mem.sv ====
// four-byte store of alarm minute/hour match values
// assumes writes arrive already masked to implemented bits
`timescale 1ns/1ps
`include "ahm_consts.svh"
module ahm_match_mem (
   // clock and reset
   input wire logic   clock_i,
   input wire logic   rst_i,
   // store port
   ahm_mem_if.mem     mp
);
   wire [3:0][7:0]           store_w;
   ahm_pkg::ahm_byte_t       rdata_ff;

   // one register per byte, so no variable is written by more than one process
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_byte
         ahm_pkg::ahm_byte_t byte_ff;
         wire                wr_hit = mp.we && (mp.waddr == ahm_pkg::ahm_idx_t'(g));
         always_ff @(posedge clock_i) begin
            if (rst_i) begin
               byte_ff <= `AHM_RESET_BYTE;
            end else if (wr_hit) begin
               byte_ff <= mp.wdata;
            end
         end
         assign store_w[g] = byte_ff;
      end
   endgenerate

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         rdata_ff <= `AHM_RESET_BYTE;
      end else begin
         rdata_ff <= store_w[mp.raddr];
      end
   end

   assign mp.rdata = rdata_ff;
   assign mp.vals  = store_w;
endmodule

// ==== logic/ahm_alarm_regs.sv ====
// alarm minute/hour match registers behind a two-wire serial slave
// assumes scl/sda already synchronous to clock_i; open-drain wire resolved outside
`timescale 1ns/1ps
`include "ahm_consts.svh"
module ahm_alarm_regs #(
   parameter logic [6:0] DEV_ADDR = `AHM_DEV_ADDR
) (
   // clock and reset
   input  wire logic               clock_i,
   input  wire logic               rst_i,
   // two-wire serial bus
   input  wire logic               scl_i,
   input  wire logic               sda_i,
   output wire logic               sda_o,
   output wire logic               sda_oe_o,
   // timekeeping side
   input  wire logic               format_12h_i,
   input  wire logic [7:0]         time_min_i,
   input  wire logic [7:0]         time_hour_i,
   input  wire logic [1:0][2:0]    alarm_match_select_i,
   // flag-set request per alarm
   output wire logic [1:0]         alarm_match_o
);
   ahm_mem_if mif ();

   ahm_match_mem u_mem (
      .clock_i (clock_i),
      .rst_i   (rst_i),
      .mp      (mif.mem)
   );

   // {hit, alarm number, hour}
   function automatic logic [2:0] ahm_decode(input logic [7:0] a);
      case (a)
         `AHM_ALM0_MIN_ADDR:  ahm_decode = 3'h4;
         `AHM_ALM0_HOUR_ADDR: ahm_decode = 3'h5;
         `AHM_ALM1_MIN_ADDR:  ahm_decode = 3'h6;
         `AHM_ALM1_HOUR_ADDR: ahm_decode = 3'h7;
         default:             ahm_decode = 3'h0;
      endcase
   endfunction

   ahm_pkg::ahm_state_t state_ff, nxt_state;
   logic [3:0]          cnt_ff, nxt_cnt;
   ahm_pkg::ahm_byte_t  shift_ff, nxt_shift;
   ahm_pkg::ahm_byte_t  ptr_ff, nxt_ptr;
   logic                rw_ff, nxt_rw;
   logic                drive_ff, nxt_drive;
   logic                scl_q_ff, sda_q_ff;
   logic [1:0]          match_ff, nxt_match;
   logic                wr_byte;

   wire       scl_rise  = scl_i & ~scl_q_ff;
   wire       scl_fall  = ~scl_i & scl_q_ff;
   wire       bus_start = scl_i & scl_q_ff & sda_q_ff & ~sda_i;
   wire       bus_stop  = scl_i & scl_q_ff & ~sda_q_ff & sda_i;
   wire       byte_done = (cnt_ff == `AHM_BYTE_BITS);
   wire [2:0] ptr_dec   = ahm_decode(ptr_ff);
   wire       ptr_hit   = ptr_dec[2];
   wire       ptr_hour  = ptr_dec[0];

   // read view: bit 7 zero, hour bit 6 shows the live format
   wire [7:0] rd_min    = mif.rdata & `AHM_MIN_MASK;                       // [R1]
   wire [7:0] rd_hour   = (mif.rdata & `AHM_HOUR_MASK)
                          | ({7'h00, format_12h_i} << `AHM_FMT_BIT);         // [R6]
   wire [7:0] rd_byte   = !ptr_hit ? `AHM_RESET_BYTE : (ptr_hour ? rd_hour : rd_min);
   // writes drop bit 7 and the read-only format bit
   wire [7:0] wr_val    = shift_ff & (ptr_hour ? `AHM_HOUR_MASK : `AHM_MIN_MASK); // [R1] [R6]

   assign mif.we    = wr_byte & ptr_hit;
   assign mif.waddr = ptr_dec[1:0];
   assign mif.wdata = wr_val;                                              // [R2] [R3] [R4] [R5]
   assign mif.raddr = ptr_dec[1:0];
   assign sda_o     = 1'b0;
   assign sda_oe_o  = drive_ff;
   assign alarm_match_o = match_ff;

   always_comb begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff;
      nxt_shift = shift_ff;
      nxt_ptr   = ptr_ff;
      nxt_rw    = rw_ff;
      nxt_drive = drive_ff;
      wr_byte   = 1'b0;
      if (bus_start) begin
         nxt_state = ahm_pkg::AHM_ADDR;
         nxt_cnt   = 4'h0;
         nxt_drive = 1'b0;
      end else if (bus_stop) begin
         nxt_state = ahm_pkg::AHM_IDLE;
         nxt_drive = 1'b0;
      end else begin
         case (state_ff)
            ahm_pkg::AHM_ADDR, ahm_pkg::AHM_PTR, ahm_pkg::AHM_WDATA: begin
               if (scl_rise && !byte_done) begin
                  nxt_shift = {shift_ff[6:0], sda_i};
                  nxt_cnt   = cnt_ff + 4'h1;
               end else if (scl_fall && byte_done) begin
                  nxt_cnt   = 4'h0;
                  nxt_drive = 1'b1;
                  if (state_ff == ahm_pkg::AHM_ADDR) begin
                     nxt_rw    = shift_ff[0];
                     nxt_state = ahm_pkg::AHM_ADDR_ACK;
                     if (shift_ff[7:1] != DEV_ADDR) begin
                        nxt_drive = 1'b0;
                        nxt_state = ahm_pkg::AHM_IDLE;
                     end
                  end else if (state_ff == ahm_pkg::AHM_PTR) begin
                     nxt_ptr   = shift_ff;
                     nxt_state = ahm_pkg::AHM_PTR_ACK;
                  end else begin
                     wr_byte   = 1'b1;
                     nxt_ptr   = ptr_ff + 8'h01;
                     nxt_state = ahm_pkg::AHM_WDATA_ACK;
                  end
               end
            end
            ahm_pkg::AHM_ADDR_ACK, ahm_pkg::AHM_PTR_ACK, ahm_pkg::AHM_WDATA_ACK: begin
               if (scl_fall) begin
                  nxt_drive = 1'b0;
                  nxt_cnt   = 4'h0;
                  if (state_ff == ahm_pkg::AHM_ADDR_ACK && rw_ff) begin
                     nxt_shift = rd_byte;
                     nxt_drive = ~rd_byte[7];
                     nxt_state = ahm_pkg::AHM_RDATA;
                  end else if (state_ff == ahm_pkg::AHM_ADDR_ACK) begin
                     nxt_state = ahm_pkg::AHM_PTR;
                  end else begin
                     nxt_state = ahm_pkg::AHM_WDATA;
                  end
               end
            end
            ahm_pkg::AHM_RDATA: begin
               if (scl_fall && cnt_ff == `AHM_LAST_BIT) begin
                  nxt_drive = 1'b0;
                  nxt_ptr   = ptr_ff + 8'h01;
                  nxt_state = ahm_pkg::AHM_RACK;
               end else if (scl_fall) begin
                  nxt_shift = {shift_ff[6:0], 1'b0};
                  nxt_drive = ~shift_ff[6];
                  nxt_cnt   = cnt_ff + 4'h1;
               end
            end
            ahm_pkg::AHM_RACK: begin
               // master nack ends the read; ack streams the next byte
               if (scl_rise && sda_i) begin
                  nxt_state = ahm_pkg::AHM_IDLE;
               end else if (scl_fall) begin
                  nxt_shift = rd_byte;
                  nxt_drive = ~rd_byte[7];
                  nxt_cnt   = 4'h0;
                  nxt_state = ahm_pkg::AHM_RDATA;
               end
            end
            ahm_pkg::AHM_IDLE: begin
               nxt_drive = 1'b0;
            end
            default: begin
               nxt_state = ahm_pkg::AHM_IDLE;
               nxt_drive = 1'b0;
            end
         endcase
      end
   end

   // match compare, one lane per alarm; BCD fields compared bit for bit
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_alarm
         wire [7:0] min_v    = mif.vals[2*g];
         wire [7:0] hour_v   = mif.vals[2*g+1];
         wire       min_eq   = (min_v[6:0] == time_min_i[6:0]);           // [R9]
         // bit 5 is PM in 12h and tens bit in 24h, so one compare covers both
         wire       hour_eq  = (hour_v[5:0] == time_hour_i[5:0]);         // [R9]
         wire       sel_min  = (alarm_match_select_i[g] == `AHM_SEL_MIN);
         wire       sel_hour = (alarm_match_select_i[g] == `AHM_SEL_HOUR);
         // level held while matching, so a cleared flag is set again
         assign nxt_match[g] = (sel_min & min_eq) | (sel_hour & hour_eq); // [R7] [R8]
      end
   endgenerate

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         state_ff <= ahm_pkg::AHM_IDLE;
         cnt_ff   <= 4'h0;
         shift_ff <= `AHM_RESET_BYTE;
         ptr_ff   <= `AHM_RESET_BYTE;
         rw_ff    <= 1'b0;
         drive_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff   <= nxt_cnt;
         shift_ff <= nxt_shift;
         ptr_ff   <= nxt_ptr;
         rw_ff    <= nxt_rw;
         drive_ff <= nxt_drive;
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         scl_q_ff <= 1'b1;
         sda_q_ff <= 1'b1;
         match_ff <= 2'h0;
      end else begin
         scl_q_ff <= scl_i;
         sda_q_ff <= sda_i;
         match_ff <= nxt_match;
      end
   end

   property p_min_msb_zero;
      @(posedge clock_i) disable iff (rst_i)
      (ptr_hit && !ptr_hour) |-> (rd_byte[7] == 1'b0);
   endproperty
   a_min_msb_zero: assert property (p_min_msb_zero) else $error("minute bit 7 not zero"); // [R1]

   property p_min_store;
      @(posedge clock_i) disable iff (rst_i)
      (mif.we && !ptr_hour) |=> (mif.vals[$past(mif.waddr)] == ($past(shift_ff) & `AHM_MIN_MASK));
   endproperty
   a_min_store: assert property (p_min_store) else $error("minute digits not stored"); // [R2]

   property p_min_ones;
      @(posedge clock_i) disable iff (rst_i)
      (mif.we && !ptr_hour) ##1 (state_ff == ahm_pkg::AHM_WDATA_ACK)
         |-> (mif.vals[$past(mif.waddr, 1)][3:0] == $past(shift_ff[3:0], 1));
   endproperty
   a_min_ones: assert property (p_min_ones) else $error("minute ones lost"); // [R3]

   property p_hour_tens;
      @(posedge clock_i) disable iff (rst_i)
      (mif.we && ptr_hour) |=> (mif.vals[$past(mif.waddr)][5:4] == $past(shift_ff[5:4]))
                               && (mif.vals[$past(mif.waddr)][7:6] == 2'h0);
   endproperty
   a_hour_tens: assert property (p_hour_tens) else $error("hour tens wrong"); // [R4]

   property p_hour_ones;
      @(posedge clock_i) disable iff (rst_i)
      (mif.we && ptr_hour) |=> (mif.vals[$past(mif.waddr)][3:0] == $past(shift_ff[3:0]));
   endproperty
   a_hour_ones: assert property (p_hour_ones) else $error("hour ones wrong"); // [R5]

   property p_hour_fmt;
      @(posedge clock_i) disable iff (rst_i)
      (ptr_hit && ptr_hour) |-> (rd_byte[6] == format_12h_i) && !rd_byte[7];
   endproperty
   a_hour_fmt: assert property (p_hour_fmt) else $error("hour format bit wrong"); // [R6]

   property p_min_match;
      @(posedge clock_i) disable iff (rst_i)
      (alarm_match_select_i[0] == `AHM_SEL_MIN && mif.vals[0][6:0] == time_min_i[6:0])
         |=> alarm_match_o[0];
   endproperty
   a_min_match: assert property (p_min_match) else $error("minute match missed"); // [R7]

   property p_hour_match;
      @(posedge clock_i) disable iff (rst_i)
      (alarm_match_select_i[1] == `AHM_SEL_HOUR && mif.vals[3][5:0] == time_hour_i[5:0])
         |=> alarm_match_o[1];
   endproperty
   a_hour_match: assert property (p_hour_match) else $error("hour match missed"); // [R7]

   property p_no_false_set;
      @(posedge clock_i) disable iff (rst_i)
      (alarm_match_select_i[0] != `AHM_SEL_MIN && alarm_match_select_i[0] != `AHM_SEL_HOUR)
         |=> !alarm_match_o[0];
   endproperty
   a_no_false_set: assert property (p_no_false_set) else $error("flag set without match"); // [R8]

   property p_bcd_ones;
      @(posedge clock_i) disable iff (rst_i)
      (alarm_match_o[0] && $past(alarm_match_select_i[0]) == `AHM_SEL_MIN)
         |-> ($past(time_min_i[3:0]) == $past(mif.vals[0][3:0]));
   endproperty
   a_bcd_ones: assert property (p_bcd_ones) else $error("match without equal digits"); // [R9]

   c_write: cover property (@(posedge clock_i) disable iff (rst_i) mif.we);
   c_read:  cover property (@(posedge clock_i) disable iff (rst_i)
                            state_ff == ahm_pkg::AHM_RDATA ##1 state_ff == ahm_pkg::AHM_RACK);
   c_match: cover property (@(posedge clock_i) disable iff (rst_i) alarm_match_o[1]);
endmodule

// ==== tb/ahm_host_model.sv ====
// two-wire bus master standing in for the host processor
// assumes the bench resolves the open-drain sda wire with a pull-up
`timescale 1ns/1ps
module ahm_host_model (
   // clock
   input  wire logic clock_i,
   // two-wire bus
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_pull_o
);
   // clocks per scl half period; the bench raises it to act as a slow host
   int half = 4;

   initial begin
      scl_o = 1'b1;
      sda_pull_o = 1'b0;
   end

   // all changes land on falling edges, away from the design's sampling edge
   task automatic wait_half();
      repeat (half) @(negedge clock_i);
   endtask

   // also serves as a repeated start from scl low
   task automatic start_cond();
      sda_pull_o = 1'b0;
      wait_half();
      scl_o = 1'b1;
      wait_half();
      sda_pull_o = 1'b1;
      wait_half();
      scl_o = 1'b0;
   endtask

   task automatic stop_cond();
      sda_pull_o = 1'b1;
      wait_half();
      scl_o = 1'b1;
      wait_half();
      sda_pull_o = 1'b0;
      wait_half();
   endtask

   // msb first; ack is high when the slave pulled sda low in the ninth bit
   task automatic send_byte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         sda_pull_o = ~b[i];
         wait_half();
         scl_o = 1'b1;
         wait_half();
         scl_o = 1'b0;
      end
      sda_pull_o = 1'b0;
      wait_half();
      scl_o = 1'b1;
      wait_half();
      ack = ~sda_i;
      scl_o = 1'b0;
   endtask

   // master_ack high asks for a further byte, low ends the read
   task automatic recv_byte(input logic master_ack, output logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         sda_pull_o = 1'b0;
         wait_half();
         scl_o = 1'b1;
         wait_half();
         b[i] = sda_i;
         scl_o = 1'b0;
      end
      sda_pull_o = master_ack;
      wait_half();
      scl_o = 1'b1;
      wait_half();
      scl_o = 1'b0;
      sda_pull_o = 1'b0;
   endtask
endmodule

// ==== tb/ahm_alarm_regs_tb.sv ====
// self-checking bench for the alarm minute/hour match registers
// assumes a pull-up on sda and the host model as the only bus master
`timescale 1ns/1ps
`include "ahm_consts.svh"
module ahm_alarm_regs_tb;
   logic              clock_i;
   logic              rst_i;
   logic              scl;
   logic              host_pull;
   logic              sda_oe;
   logic              sda_val;
   logic              sda_w;
   logic              format_12h;
   logic [7:0]        time_min;
   logic [7:0]        time_hour;
   logic [1:0][2:0]   sel;
   logic [1:0]        match;
   logic              ack;
   logic [15:0]       rd_data;
   int                failures = 0;
   int                check_count = 0;
   int                cycles = 0;
   localparam int     LIMIT = 40000;

   // open-drain wire: the block's data value shows only while it drives, pull-up otherwise
   assign sda_w = (sda_oe ? sda_val : 1'b1) & ~host_pull;

   ahm_alarm_regs #(.DEV_ADDR(`AHM_DEV_ADDR)) ahm_alarm_regs_i (
      .clock_i              (clock_i),
      .rst_i                (rst_i),
      .scl_i                (scl),
      .sda_i                (sda_w),
      .sda_o                (sda_val),
      .sda_oe_o             (sda_oe),
      .format_12h_i         (format_12h),
      .time_min_i           (time_min),
      .time_hour_i          (time_hour),
      .alarm_match_select_i (sel),
      .alarm_match_o        (match)
   );

   ahm_host_model ahm_host_model_i (
      .clock_i    (clock_i),
      .sda_i      (sda_w),
      .scl_o      (scl),
      .sda_pull_o (host_pull)
   );

   always #2.5 clock_i = ~clock_i;

   always @(posedge clock_i) begin
      cycles++;
      if (cycles == LIMIT) begin
         failures++;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      if (failures == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic addr_ptr(input logic [7:0] ptr);
      ahm_host_model_i.start_cond();
      ahm_host_model_i.send_byte({`AHM_DEV_ADDR, 1'b0}, ack);
      check8("addr ack", 8'h01, {7'h00, ack});
      ahm_host_model_i.send_byte(ptr, ack);
      check8("ptr ack", 8'h01, {7'h00, ack});
   endtask

   // one or two data bytes; the second goes to the next pointer
   task automatic wr(input logic [7:0] ptr, input int n, input logic [15:0] d);
      addr_ptr(ptr);
      ahm_host_model_i.send_byte(d[15:8], ack);
      check8("data ack", 8'h01, {7'h00, ack});
      if (n == 2) begin
         ahm_host_model_i.send_byte(d[7:0], ack);
         check8("data ack", 8'h01, {7'h00, ack});
      end
      ahm_host_model_i.stop_cond();
   endtask

   task automatic rd(input logic [7:0] ptr, input int n, output logic [15:0] d);
      addr_ptr(ptr);
      ahm_host_model_i.start_cond();
      ahm_host_model_i.send_byte({`AHM_DEV_ADDR, 1'b1}, ack);
      check8("raddr ack", 8'h01, {7'h00, ack});
      d = 16'h0000;
      ahm_host_model_i.recv_byte(n == 2, d[15:8]);
      if (n == 2) begin
         ahm_host_model_i.recv_byte(1'b0, d[7:0]);
      end
      ahm_host_model_i.stop_cond();
   endtask

   task automatic rd_chk(input logic [7:0] ptr, input logic [7:0] exp);
      rd(ptr, 1, rd_data);
      check8("reg", exp, rd_data[15:8]);
   endtask

   // inputs change at a falling edge; the match output lands one edge later
   task automatic match_chk(input logic [2:0] s0, input logic [2:0] s1, input logic [1:0] exp);
      sel = {s1, s0};
      @(negedge clock_i);
      check8("match", {6'h00, exp}, {6'h00, match});
   endtask

   initial begin
      clock_i = 1'b0;
      rst_i = 1'b1;
      format_12h = 1'b0;
      time_min = 8'h99;
      time_hour = 8'h3F;
      sel = {3'h0, 3'h0};
      repeat (6) @(negedge clock_i);
      rst_i = 1'b0;
      @(negedge clock_i);
      rd_chk(`AHM_ALM0_MIN_ADDR, `AHM_RESET_BYTE);
      rd_chk(`AHM_ALM0_HOUR_ADDR, `AHM_RESET_BYTE);
      rd_chk(`AHM_ALM1_MIN_ADDR, `AHM_RESET_BYTE);
      rd_chk(`AHM_ALM1_HOUR_ADDR, `AHM_RESET_BYTE);
      format_12h = 1'b1;
      rd_chk(`AHM_ALM0_HOUR_ADDR, 8'h40);
      // bit 7 written high must not stick; 12-hour pm twelve
      wr(`AHM_ALM0_MIN_ADDR, 2, 16'hD9_72);
      rd(`AHM_ALM0_MIN_ADDR, 2, rd_data);
      check8("min0", 8'h59, rd_data[15:8]);
      check8("hour0", 8'h72, rd_data[7:0]);
      format_12h = 1'b0;
      rd_chk(`AHM_ALM0_HOUR_ADDR, 8'h32);
      // slow host for the second unit
      ahm_host_model_i.half = 12;
      wr(`AHM_ALM1_MIN_ADDR, 2, 16'h45_23);
      rd(`AHM_ALM1_MIN_ADDR, 2, rd_data);
      check8("min1", 8'h45, rd_data[15:8]);
      check8("hour1", 8'h23, rd_data[7:0]);
      ahm_host_model_i.half = 4;
      // unmapped pointer is acked but holds nothing
      wr(8'h0A, 1, 16'h33_00);
      rd_chk(8'h0A, 8'h00);
      rd_chk(`AHM_ALM0_MIN_ADDR, 8'h59);
      // foreign address is not acked
      ahm_host_model_i.start_cond();
      ahm_host_model_i.send_byte({`AHM_DEV_ADDR ^ 7'h01, 1'b0}, ack);
      check8("foreign ack", 8'h00, {7'h00, ack});
      ahm_host_model_i.stop_cond();
      // every select code against alarm 0 with minutes and hours both equal
      time_min = 8'h59;
      time_hour = 8'h32;
      for (int c = 0; c < 8; c++) begin
         match_chk(c[2:0], 3'h0, {1'b0, c == 1 || c == 2});
      end
      match_chk(`AHM_SEL_MIN, `AHM_SEL_HOUR, 2'b01);
      time_min = 8'h58;
      match_chk(`AHM_SEL_MIN, `AHM_SEL_MIN, 2'b00);
      time_min = 8'h45;
      time_hour = 8'h23;
      match_chk(`AHM_SEL_HOUR, `AHM_SEL_MIN, 2'b10);
      match_chk(`AHM_SEL_MIN, `AHM_SEL_HOUR, 2'b10);
      // binary fifteen must not match a stored bcd fifteen
      wr(`AHM_ALM1_MIN_ADDR, 1, 16'h15_00);
      time_min = 8'h0F;
      match_chk(3'h0, `AHM_SEL_MIN, 2'b00);
      time_min = 8'h15;
      match_chk(3'h0, `AHM_SEL_MIN, 2'b10);
      report_and_stop();
   end
endmodule
